// >>> l2_sram_pkg.sv
// Notes on behaviour
// - Port 0 is a 64-bit core port; port 1 is a 32-bit DMA port.
// - Each port has separate read and write channels working concurrently.
// - Runs on the system clock; one bus word per channel per cycle.
// - Every access becomes a 64-bit access to the array.
// - 1 MB array in eight banks, ECC enabled per bank.
// - 8/16-bit access to an ECC bank adds two cycles of latency.
// - Sub-32-bit write to an ECC bank is read-modify-write, three cycles.
// - Per-port read and write priority counts settle same-bank conflicts.
// - Sequential and random addresses see identical timing, no page penalty.
// - With ECC off, narrow writes need no read-modify-write nor delay.
package l2_sram_pkg;
    localparam int ADDR_W = 20;
    localparam int WORDS = 131072;
    localparam int BANK_LSB = 17;
    localparam int CHK_W = 7;
    localparam int CNT_W = 4;
    localparam int CORE_F_LSB = 0;
    localparam int DMA_F_LSB = 4;
    localparam logic [7:0] OFS_RPC = 8'h00;
    localparam logic [7:0] OFS_WPC = 8'h04;
    localparam logic [7:0] OFS_ECC = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] RST_RPC = 8'h00;
    localparam logic [7:0] RST_WPC = 8'h00;
    localparam logic [7:0] RST_ECC_EN = 8'hFF;
    // Base wait of a losing DMA request before the priority counts apply
    localparam logic [4:0] ARB_BASE = 5'h03;
    localparam logic [4:0] WAIT_MAX = 5'h1F;
    localparam logic [1:0] SZ_8 = 2'h0;
    localparam logic [1:0] SZ_16 = 2'h1;
    localparam logic [1:0] SZ_32 = 2'h2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACC = 2'b01,
        ST_EXT1 = 2'b10,
        ST_EXT2 = 2'b11
    } eng_state_type;
endpackage

// >>> l2_ecc_gen.sv
`timescale 1ns/1ps
`default_nettype none
module l2_ecc_gen
    import l2_sram_pkg::*;
(
    input wire logic [31:0] data_i,
    output logic [CHK_W-1:0] check_o
);
    // Six Hamming parity bits plus one overall parity per 32-bit granule
    always_comb begin
        check_o = '0;
        for (int i = 0; i < 32; i++) begin
            for (int k = 0; k < CHK_W - 1; k++) begin
                if ((((i + 3) >> k) & 1) == 1) begin
                    check_o[k] = check_o[k] ^ data_i[i];
                end
            end
            check_o[CHK_W-1] = check_o[CHK_W-1] ^ data_i[i];
        end
    end
endmodule
`default_nettype wire

// >>> l2_sram_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module l2_sram_ctrl
    import l2_sram_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CORE_RD_REQ_I,
    input wire logic [ADDR_W-1:0] CORE_RD_ADDR_I,
    input wire logic [1:0] CORE_RD_SIZE_I,
    output logic CORE_RD_ACK_O,
    output logic [63:0] CORE_RD_DATA_O,
    output logic CORE_RD_VALID_O,
    input wire logic CORE_WR_REQ_I,
    input wire logic [ADDR_W-1:0] CORE_WR_ADDR_I,
    input wire logic [1:0] CORE_WR_SIZE_I,
    input wire logic [63:0] CORE_WR_DATA_I,
    output logic CORE_WR_ACK_O,
    output logic CORE_WR_DONE_O,
    input wire logic DMA_RD_REQ_I,
    input wire logic [ADDR_W-1:0] DMA_RD_ADDR_I,
    input wire logic [1:0] DMA_RD_SIZE_I,
    output logic DMA_RD_ACK_O,
    output logic [31:0] DMA_RD_DATA_O,
    output logic DMA_RD_VALID_O,
    input wire logic DMA_WR_REQ_I,
    input wire logic [ADDR_W-1:0] DMA_WR_ADDR_I,
    input wire logic [1:0] DMA_WR_SIZE_I,
    input wire logic [31:0] DMA_WR_DATA_I,
    output logic DMA_WR_ACK_O,
    output logic DMA_WR_DONE_O,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O
);
    // ****************************************************
    // State
    // ****************************************************
    // Channel c: 0 core read, 1 core write, 2 DMA read, 3 DMA write
    typedef struct packed {
        logic [3:0][1:0] st;
        logic [3:0][ADDR_W-1:0] addr;
        logic [3:0][1:0] size;
        logic [1:0][63:0] wdata;
        logic [1:0][63:0] rdata;
        logic [3:0] resp;
        logic [1:0][4:0] wait_cnt;
        logic [7:0] rpc;
        logic [7:0] wpc;
        logic [7:0] ecc_en;
        logic [15:0] err_cnt;
        logic [31:0] reg_rdata;
    } state_type;

    localparam state_type RST_STATE = '{rpc: RST_RPC, wpc: RST_WPC,
        ecc_en: RST_ECC_EN, default: '0};

    state_type cur;
    state_type nxt;
    logic [63:0] mem_reg [WORDS];
    logic [2*CHK_W-1:0] chk_reg [WORDS];

    logic [3:0] req;
    logic [3:0][ADDR_W-1:0] in_addr;
    logic [3:0][1:0] in_size;
    logic [1:0][63:0] in_wdata;
    logic [3:0][ADDR_W-4:0] idx;
    logic [3:0][2:0] bank;
    logic [3:0][63:0] word;
    logic [3:0][63:0] rd_word;
    logic [3:0][63:0] enc_in;
    logic [3:0][2*CHK_W-1:0] old_chk;
    logic [3:0][2*CHK_W-1:0] new_chk;
    logic [3:0][7:0] be;
    logic [3:0] ext;
    logic [3:0] conflict;
    logic [3:0] locked;
    logic [3:0] grant;
    logic [3:0] done;
    logic [3:0] ack;
    logic [3:0] busy;
    logic [1:0] won;
    logic [1:0][4:0] thr;
    logic [1:0] wr_en;
    logic [1:0] rd_err;
    logic [15:0] err_add;

    function automatic logic [7:0] lanes(input logic [2:0] a,
        input logic [1:0] sz, input logic dma);
        logic [7:0] m;
        m = 8'hFF;
        case (sz)
            SZ_8: m = 8'h01 << a;
            SZ_16: m = 8'h03 << {a[2:1], 1'b0};
            SZ_32: m = 8'h0F << {a[2], 2'b00};
            default: m = dma ? 8'h0F << {a[2], 2'b00} : 8'hFF;
        endcase
        return m;
    endfunction

    function automatic logic [63:0] merge(input logic [63:0] old_w,
        input logic [63:0] new_w, input logic [7:0] lane);
        logic [63:0] m;
        m = old_w;
        for (int b = 0; b < 8; b++) begin
            if (lane[b]) begin
                m[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic [4:0] thresh(input logic [3:0] core,
        input logic [3:0] dma);
        logic [5:0] t;
        t = 6'(ARB_BASE) + 6'(core);
        return (t > 6'(dma)) ? 5'(t - 6'(dma)) : 5'h01;
    endfunction

    // ****************************************************
    // Port mapping
    // ****************************************************
    assign req = {DMA_WR_REQ_I, DMA_RD_REQ_I, CORE_WR_REQ_I, CORE_RD_REQ_I};
    assign in_addr = {DMA_WR_ADDR_I, DMA_RD_ADDR_I, CORE_WR_ADDR_I,
        CORE_RD_ADDR_I};
    assign in_size = {DMA_WR_SIZE_I, DMA_RD_SIZE_I, CORE_WR_SIZE_I,
        CORE_RD_SIZE_I};
    assign in_wdata = {{2{DMA_WR_DATA_I}}, CORE_WR_DATA_I};
    assign thr[0] = thresh(cur.rpc[CORE_F_LSB +: CNT_W],
        cur.rpc[DMA_F_LSB +: CNT_W]);
    assign thr[1] = thresh(cur.wpc[CORE_F_LSB +: CNT_W],
        cur.wpc[DMA_F_LSB +: CNT_W]);

    // ****************************************************
    // Channel engines and bank arbitration
    // ****************************************************
    for (genvar c = 0; c < 4; c++) begin : g_ch
        localparam int P = c / 2;
        localparam int D = c % 2;
        localparam int O = c ^ 2;
        assign idx[c] = cur.addr[c][ADDR_W-1:3];
        assign bank[c] = cur.addr[c][ADDR_W-1:BANK_LSB];
        assign word[c] = mem_reg[idx[c]];
        assign old_chk[c] = chk_reg[idx[c]];
        assign be[c] = lanes(cur.addr[c][2:0], cur.size[c], P == 1);
        assign rd_word[c] = (P == 1) ? {32'h00000000, cur.addr[c][2] ?
            word[c][63:32] : word[c][31:0]} : word[c];
        assign ext[c] = (cur.size[c] < SZ_32) && cur.ecc_en[bank[c]];
        assign conflict[c] = cur.st[c] == ST_ACC && cur.st[O] == ST_ACC
            && bank[c] == bank[O];
        assign locked[c] = D == 1 && bank[O] == bank[c]
            && (cur.st[O] == ST_EXT1 || cur.st[O] == ST_EXT2);
        // Core wins a conflict until the DMA wait reaches its threshold
        assign grant[c] = cur.st[c] == ST_ACC && !locked[c]
            && (!conflict[c] || ((P == 1) == won[D]));
        assign enc_in[c] = (D == 1) ? merge(word[c], cur.wdata[P], be[c])
            : word[c];
        assign done[c] = (cur.st[c] == ST_ACC && grant[c] && !ext[c])
            || cur.st[c] == ST_EXT2;
        assign ack[c] = cur.st[c] == ST_IDLE
            || (cur.st[c] == ST_ACC && grant[c] && !ext[c]);
        assign busy[c] = cur.st[c] != ST_IDLE;
        for (genvar g = 0; g < 2; g++) begin : g_gr
            l2_ecc_gen u_ecc (
                .data_i(enc_in[c][32*g +: 32]),
                .check_o(new_chk[c][CHK_W*g +: CHK_W])
            );
        end
    end

    for (genvar p = 0; p < 2; p++) begin : g_port
        assign won[p] = cur.wait_cnt[p] >= thr[p];
        assign wr_en[p] = done[2*p+1];
        assign rd_err[p] = cur.st[2*p] == ST_ACC && grant[2*p]
            && cur.ecc_en[bank[2*p]] && new_chk[2*p] != old_chk[2*p];
    end
    assign err_add = 16'(rd_err[0]) + 16'(rd_err[1]);

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        nxt = cur;
        nxt.resp = done;
        nxt.reg_rdata = '0;
        for (int c = 0; c < 4; c++) begin
            case (cur.st[c])
                ST_IDLE: begin
                    if (req[c]) begin
                        nxt.st[c] = ST_ACC;
                    end
                end
                ST_ACC: begin
                    if (grant[c] && ext[c]) begin
                        nxt.st[c] = ST_EXT1;
                    end else if (grant[c]) begin
                        nxt.st[c] = req[c] ? ST_ACC : ST_IDLE;
                    end
                end
                ST_EXT1: begin
                    nxt.st[c] = ST_EXT2;
                end
                default: begin
                    nxt.st[c] = ST_IDLE;
                end
            endcase
            if (ack[c] && req[c]) begin
                nxt.addr[c] = in_addr[c];
                nxt.size[c] = in_size[c];
                if (c % 2 == 1) begin
                    nxt.wdata[c/2] = in_wdata[c/2];
                end
            end
            if (c % 2 == 0 && cur.st[c] == ST_ACC && grant[c]) begin
                nxt.rdata[c/2] = rd_word[c];
            end
        end
        for (int d = 0; d < 2; d++) begin
            if (grant[2+d]) begin
                nxt.wait_cnt[d] = '0;
            end else if (conflict[2+d] && cur.wait_cnt[d] != WAIT_MAX) begin
                nxt.wait_cnt[d] = cur.wait_cnt[d] + 5'h01;
            end
        end
        nxt.err_cnt = cur.err_cnt + err_add;
        if (REG_WR_I) begin
            if (REG_ADDR_I == OFS_RPC) begin
                nxt.rpc = REG_WDATA_I[7:0];
            end else if (REG_ADDR_I == OFS_WPC) begin
                nxt.wpc = REG_WDATA_I[7:0];
            end else if (REG_ADDR_I == OFS_ECC) begin
                nxt.ecc_en = REG_WDATA_I[7:0];
            end else if (REG_ADDR_I == OFS_STAT) begin
                nxt.err_cnt = err_add;
            end
        end
        if (REG_RD_I) begin
            if (REG_ADDR_I == OFS_RPC) begin
                nxt.reg_rdata = {24'h000000, cur.rpc};
            end else if (REG_ADDR_I == OFS_WPC) begin
                nxt.reg_rdata = {24'h000000, cur.wpc};
            end else if (REG_ADDR_I == OFS_ECC) begin
                nxt.reg_rdata = {24'h000000, cur.ecc_en};
            end else if (REG_ADDR_I == OFS_STAT) begin
                nxt.reg_rdata = {12'h000, busy, cur.err_cnt};
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cur <= RST_STATE;
        end else begin
            cur <= nxt;
        end
    end

    // ****************************************************
    // Array, written with merged lanes and fresh check bits
    // ****************************************************
    always_ff @(posedge CLK_I) begin
        for (int p = 0; p < 2; p++) begin
            if (wr_en[p]) begin
                mem_reg[idx[2*p+1]] <= enc_in[2*p+1];
                chk_reg[idx[2*p+1]] <= new_chk[2*p+1];
            end
        end
    end

    assign CORE_RD_ACK_O = ack[0];
    assign CORE_WR_ACK_O = ack[1];
    assign DMA_RD_ACK_O = ack[2];
    assign DMA_WR_ACK_O = ack[3];
    assign CORE_RD_DATA_O = cur.rdata[0];
    assign DMA_RD_DATA_O = cur.rdata[1][31:0];
    assign CORE_RD_VALID_O = cur.resp[0];
    assign CORE_WR_DONE_O = cur.resp[1];
    assign DMA_RD_VALID_O = cur.resp[2];
    assign DMA_WR_DONE_O = cur.resp[3];
    assign REG_RDATA_O = cur.reg_rdata;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_two_idle_then_valid;
        !CORE_RD_VALID_O ##1 !CORE_RD_VALID_O ##1 CORE_RD_VALID_O;
    endsequence
    sequence s_rmw_steps;
        !wr_en[0] ##1 !wr_en[0] ##1 wr_en[0] ##1 CORE_WR_DONE_O;
    endsequence

    AST_RD_ONE_CYCLE: assert property (
        cur.st[0] == ST_ACC && grant[0] && !ext[0] |=> CORE_RD_VALID_O)
        else $error("core read answer late");
    AST_EXT_RD_LAT: assert property (
        cur.st[0] == ST_ACC && grant[0] && ext[0] |=> s_two_idle_then_valid)
        else $error("narrow ECC read latency wrong");
    AST_RMW_THREE: assert property (
        cur.st[1] == ST_ACC && grant[1] && ext[1] |-> s_rmw_steps)
        else $error("read-modify-write not three cycles");
    AST_NO_RMW_OFF: assert property (
        cur.st[3] == ST_ACC && grant[3] && !cur.ecc_en[bank[3]]
        |-> wr_en[1] ##1 DMA_WR_DONE_O)
        else $error("write to ECC-off bank delayed");
    AST_DMA_TURN: assert property (
        conflict[2] && !locked[2] && cur.wait_cnt[0] >= thr[0]
        |-> grant[2] && !grant[0])
        else $error("DMA read not given its turn");
    AST_BANK_EXCL: assert property (
        !(wr_en[0] && wr_en[1] && bank[1] == bank[3]))
        else $error("two writes to one bank");
    AST_CONCURRENT: assert property (
        cur.st[0] == ST_ACC && cur.st[1] == ST_ACC && !conflict[0]
        && !conflict[1] && !locked[1] |-> grant[0] && grant[1])
        else $error("read and write channels not concurrent");
    AST_BACK_TO_BACK: assert property (
        cur.st[2] == ST_ACC && grant[2] && !ext[2] && DMA_RD_REQ_I
        |=> cur.st[2] == ST_ACC ##0 DMA_RD_VALID_O)
        else $error("DMA reads not pipelined");
    AST_WIDE_WRITE: assert property (
        wr_en[0] && cur.size[1] == 2'h3 |-> be[1] == 8'hFF && !ext[1])
        else $error("64-bit write not a full word");
endmodule
`default_nettype wire

// >>> l2_xbar_master.sv
`timescale 1ns/1ps
`default_nettype none
module l2_xbar_master
    import l2_sram_pkg::*;
#(
    parameter int DW = 64
) (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic done_i,
    input wire logic [DW-1:0] rdata_i,
    output logic req_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [1:0] size_o,
    output logic [DW-1:0] data_o
);
    initial begin
        req_o = 1'b0;
        addr_o = '0;
        size_o = 2'h0;
        data_o = '0;
    end
    // Holds one request until n takes; span is cycles from take 1 to take n
    task automatic run(input logic [ADDR_W-1:0] a, input logic [1:0] s,
        input logic [DW-1:0] d, input int n, output int span);
        int t;
        int c;
        int first;
        span = -1;
        t = 0;
        first = 0;
        req_o <= 1'b1;
        addr_o <= a;
        size_o <= s;
        data_o <= d;
        for (c = 0; c < 200 && t < n; c++) begin
            @(posedge clk_i);
            if (ack_i === 1'b1) begin
                t++;
                if (t == 1) first = c;
                if (t == n) span = c - first;
            end
        end
        // Released lines show the inverse so stale values never look valid
        req_o <= 1'b0;
        addr_o <= ~a;
        size_o <= ~s;
        data_o <= ~d;
    endtask
    // One access; lat counts edges from the take to the answer pulse
    task automatic xfer(input logic [ADDR_W-1:0] a, input logic [1:0] s,
        input logic [DW-1:0] d, output int lat, output logic [DW-1:0] q);
        int sp;
        int c;
        lat = -1;
        q = '0;
        run(a, s, d, 1, sp);
        for (c = 1; c <= 40 && sp == 0 && lat < 0; c++) begin
            @(posedge clk_i);
            if (done_i === 1'b1) begin
                lat = c;
                q = rdata_i;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> l2_sram_dual_port_ecc_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module l2_sram_dual_port_ecc_controller_tb
    import l2_sram_pkg::*;
;
    typedef struct packed {
        int ch;
        logic [ADDR_W-1:0] a;
        logic [1:0] s;
        logic [63:0] d;
        int el;
    } row_type;
    localparam int NR = 13;
    // Channel 0 core read, 1 core write, 2 DMA read, 3 DMA write
    localparam row_type ROWS [NR] = '{
        '{1, 20'h20000, 2'h3, 64'h1122334455667788, 2},
        '{0, 20'h20000, 2'h3, 64'h1122334455667788, 2},
        '{1, 20'h20001, 2'h0, 64'h000000000000AB00, 4},
        '{0, 20'h20000, 2'h3, 64'h112233445566AB88, 2},
        '{1, 20'h20006, 2'h1, 64'hCDEF000000000000, 4},
        '{0, 20'h20000, 2'h0, 64'hCDEF33445566AB88, 4},
        '{3, 20'h20004, 2'h2, 64'h000000000BADF00D, 2},
        '{0, 20'h20000, 2'h2, 64'h0BADF00D5566AB88, 2},
        '{2, 20'h20004, 2'h3, 64'h000000000BADF00D, 2},
        '{3, 20'h20002, 2'h0, 64'h0000000000EE0000, 4},
        '{2, 20'h20000, 2'h2, 64'h0000000055EEAB88, 2},
        '{1, 20'hE0038, 2'h3, 64'h0123456789ABCDEF, 2},
        '{0, 20'hE0038, 2'h3, 64'h0123456789ABCDEF, 2}
    };
    logic clk;
    logic rst_n;
    logic cr_req, cr_ack, cr_val, cw_req, cw_ack, cw_done;
    logic dr_req, dr_ack, dr_val, dw_req, dw_ack, dw_done;
    logic [ADDR_W-1:0] cr_addr, cw_addr, dr_addr, dw_addr;
    logic [1:0] cr_size, cw_size, dr_size, dw_size;
    logic [63:0] cr_data, cw_data;
    logic [31:0] dr_data, dw_data;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic reg_wr, reg_rd;
    int num_errors, cmp_count, i, sp0, sp1, sp2, sp3;

    l2_xbar_master #(.DW(64)) m_cr (.clk_i(clk), .ack_i(cr_ack),
        .done_i(cr_val), .rdata_i(cr_data), .req_o(cr_req),
        .addr_o(cr_addr), .size_o(cr_size), .data_o());
    l2_xbar_master #(.DW(64)) m_cw (.clk_i(clk), .ack_i(cw_ack),
        .done_i(cw_done), .rdata_i(cr_data), .req_o(cw_req),
        .addr_o(cw_addr), .size_o(cw_size), .data_o(cw_data));
    l2_xbar_master #(.DW(32)) m_dr (.clk_i(clk), .ack_i(dr_ack),
        .done_i(dr_val), .rdata_i(dr_data), .req_o(dr_req),
        .addr_o(dr_addr), .size_o(dr_size), .data_o());
    l2_xbar_master #(.DW(32)) m_dw (.clk_i(clk), .ack_i(dw_ack),
        .done_i(dw_done), .rdata_i(dr_data), .req_o(dw_req),
        .addr_o(dw_addr), .size_o(dw_size), .data_o(dw_data));
    l2_sram_ctrl dut (.CLK_I(clk), .RST_N_I(rst_n),
        .CORE_RD_REQ_I(cr_req), .CORE_RD_ADDR_I(cr_addr),
        .CORE_RD_SIZE_I(cr_size), .CORE_RD_ACK_O(cr_ack),
        .CORE_RD_DATA_O(cr_data), .CORE_RD_VALID_O(cr_val),
        .CORE_WR_REQ_I(cw_req), .CORE_WR_ADDR_I(cw_addr),
        .CORE_WR_SIZE_I(cw_size), .CORE_WR_DATA_I(cw_data),
        .CORE_WR_ACK_O(cw_ack), .CORE_WR_DONE_O(cw_done),
        .DMA_RD_REQ_I(dr_req), .DMA_RD_ADDR_I(dr_addr),
        .DMA_RD_SIZE_I(dr_size), .DMA_RD_ACK_O(dr_ack),
        .DMA_RD_DATA_O(dr_data), .DMA_RD_VALID_O(dr_val),
        .DMA_WR_REQ_I(dw_req), .DMA_WR_ADDR_I(dw_addr),
        .DMA_WR_SIZE_I(dw_size), .DMA_WR_DATA_I(dw_data),
        .DMA_WR_ACK_O(dw_ack), .DMA_WR_DONE_O(dw_done),
        .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata));

    always #10 clk = ~clk;

    task automatic check(input string what, input logic [63:0] seen,
        input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // Let an edge pass so a following write never re-raises the strobe
        @(posedge clk);
    endtask
    task automatic reg_rd_t(input logic [7:0] a, output logic [31:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        q = reg_rdata;
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        check("idle ack", 64'({cr_ack, cw_ack, dr_ack, dw_ack}),
            64'hF);
        check("idle pulse", 64'({cr_val, cw_done, dr_val, dw_done}),
            64'h0);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic op(input int ch, input logic [ADDR_W-1:0] a,
        input logic [1:0] s, input logic [63:0] d, input int el);
        int lat;
        logic [63:0] q;
        logic [31:0] h;
        q = '0;
        h = '0;
        case (ch)
            0: m_cr.xfer(a, s, 64'h0, lat, q);
            1: m_cw.xfer(a, s, d, lat, q);
            2: m_dr.xfer(a, s, 32'h0, lat, h);
            default: m_dw.xfer(a, s, d[31:0], lat, h);
        endcase
        if (ch == 2) q = {32'h0, h};
        check("latency", 64'(lat), 64'(el));
        if (lat < 0) finish_test();
        if (ch == 0 || ch == 2) check("read data", q, d);
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        num_errors = 0;
        cmp_count = 0;
        do_reset();
        reg_rd_t(OFS_RPC, rv);
        check("read prio", 64'(rv), 64'h0);
        reg_rd_t(OFS_ECC, rv);
        check("ecc enable", 64'(rv), 64'hFF);
        for (i = 0; i < NR; i++) begin
            op(ROWS[i].ch, ROWS[i].a, ROWS[i].s, ROWS[i].d, ROWS[i].el);
        end
        // Four channels at once on distinct banks
        fork
            op(0, 20'hE0038, 2'h3, 64'h0123456789ABCDEF, 2);
            op(1, 20'h40000, 2'h3, 64'hA5A5A5A55A5A5A5A, 2);
            op(2, 20'h20000, 2'h2, 64'h0000000055EEAB88, 2);
            op(3, 20'h60000, 2'h2, 64'h00000000C3C3C3C3, 2);
        join
        reg_wr_t(8'h10, 32'hFFFFFFFF);
        reg_rd_t(8'h10, rv);
        check("unmapped", 64'(rv), 64'h0);
        reg_wr_t(OFS_RPC, 32'h00000010);
        reg_wr_t(OFS_WPC, 32'h00000010);
        reg_rd_t(OFS_WPC, rv);
        check("write prio", 64'(rv), 64'h10);
        // Core streams reads and writes on two banks; DMA (size 3, taken as 32-bit) contends per direction
        fork
            m_cr.run(20'h20000, 2'h3, 64'h0, 16, sp0);
            m_dr.run(20'h20000, 2'h3, 32'h0, 4, sp1);
            m_cw.run(20'h40008, 2'h3, 64'h1234, 16, sp2);
            m_dw.run(20'h40010, 2'h3, 32'h5678, 4, sp3);
        join
        check("dma read pace", 64'(sp1), 64'h9);
        check("dma write pace", 64'(sp3), 64'h9);
        repeat (4) @(posedge clk);
        reg_wr_t(OFS_ECC, 32'h000000FD);
        op(1, 20'h20003, 2'h0, 64'h0000000077000000, 2);
        op(3, 20'h20000, 2'h1, 64'h000000000000CAFE, 2);
        op(0, 20'h20000, 2'h0, 64'h0BADF00D77EECAFE, 2);
        // All channels idle and every read word from an ECC-enabled bank carried matching check bits
        reg_rd_t(OFS_STAT, rv);
        check("status", 64'(rv), 64'h0);
        do_reset();
        reg_rd_t(OFS_ECC, rv);
        check("ecc after reset", 64'(rv), 64'hFF);
        finish_test();
    end
endmodule
`default_nettype wire
